/* File: core/mcuid_pkg.sv */
// Shared constants and types of the instruction subset decoder
package mcuid_pkg;

  // Phase encoding of one instruction cycle
  localparam logic [1:0] PH_DECODE  = 2'h0;
  localparam logic [1:0] PH_READ    = 2'h1;
  localparam logic [1:0] PH_PROCESS = 2'h2;
  localparam logic [1:0] PH_WRITE   = 2'h3;

  // Opcode fields
  localparam logic [3:0] OPC_CLEAR_BIT  = 4'h9;   // bits 15:12
  localparam logic [3:0] OPC_MOVE_SRC   = 4'hc;   // first word, bits 15:12
  localparam logic [3:0] OPC_MOVE_DST   = 4'hf;   // second word prefix
  localparam logic [7:0] OPC_BRANCH_NEG = 8'he6;  // bits 15:8
  localparam logic [7:0] OPC_LOAD_BANK  = 8'h01;  // bits 15:8

  // Word field positions
  localparam int unsigned BIT_IDX_LSB = 9;
  localparam int unsigned ACCESS_POS  = 8;

  // Addressing constants
  localparam logic [7:0] IDX_LIMIT      = 8'h5f;  // highest indexed offset
  localparam logic [3:0] ACCESS_HI_BANK = 4'hf;   // upper 160 bytes of access bank
  localparam logic [3:0] ACCESS_LO_BANK = 4'h0;

  // Destinations the move may not write
  localparam logic [11:0] NO_DEST_LO = 12'hffd;
  localparam logic [11:0] NO_DEST_HI = 12'hfff;

  // Program counter
  localparam int unsigned PC_W     = 21;
  localparam logic [20:0] PC_STEP  = 21'h000002;
  localparam logic [20:0] PC_RESET = 21'h000000;

  // Reset values
  localparam logic [7:0]  BANK_RESET = 8'h00;
  localparam logic [15:0] IR_RESET   = 16'h0000;

  // Sequencer states
  typedef enum logic [1:0] {
    ST_EXEC,
    ST_BR_NOP,
    ST_MOVE2
  } mcuid_state_e;

endpackage

/* File: core/mcuid_phase_gen.sv */
// Four-phase generator of the instruction cycle
`timescale 1ns/1ps
`default_nettype none
module mcuid_phase_gen (
  input  wire logic       clk,
  input  wire logic       rstn,
  output var  logic [1:0] phase_ff
);
  logic [1:0] nxt_phase;

  // Phases roll decode, read, process, write and wrap
  always_comb
  begin
    nxt_phase = phase_ff + 2'h1;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      phase_ff <= mcuid_pkg::PH_DECODE;
    else
      phase_ff <= nxt_phase;
  end
endmodule // mcuid_phase_gen
`default_nettype wire

/* File: core/mcuid_addr_form.sv */
// Data-space address former for byte and bit instructions
`timescale 1ns/1ps
`default_nettype none
module mcuid_addr_form (
  input  wire logic [7:0]  file_addr,
  input  wire logic        access_sel,
  input  wire logic [7:0]  bank_sel,
  input  wire logic        ext_set_en,
  input  wire logic [11:0] idx_base,
  output logic      [11:0] data_addr
);
  // Access operand picks banked, indexed or fixed access bank
  always_comb
  begin
    if (access_sel)
      data_addr = {bank_sel[3:0], file_addr};
    else if (ext_set_en && (file_addr <= mcuid_pkg::IDX_LIMIT))
      data_addr = idx_base + {4'h0, file_addr};
    else if (file_addr <= mcuid_pkg::IDX_LIMIT)
      data_addr = {mcuid_pkg::ACCESS_LO_BANK, file_addr};
    else
      data_addr = {mcuid_pkg::ACCESS_HI_BANK, file_addr};
  end
endmodule // mcuid_addr_form
`default_nettype wire

/* File: core/mcuid_core.sv */
// Decode and execute of four instructions over a four-phase cycle
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Bit clear uses opcode 1001, a 3-bit index, access bit and 8-bit address, flags untouched.
// - Access operand zero selects the access bank, one selects the bank register's bank.
// - With access zero and extended set on, addresses up to 95 are indexed literal offsets.
// - Branch on minus adds two plus twice its signed offset to the counter when negative.
// - The branch offset is added after the counter has already stepped to the next word.
// - The branch is one word, one cycle untaken, two taken with an idle second cycle.
// - The move is two words: opcode 1100 with source, then prefix 1111 with destination.
// - Move source and destination span the whole 4096-byte space, ignoring banks and flags.
// - The move reads its source in cycle one and writes its destination in cycle two's Q4.
// - The move treats the accumulator as an ordinary data-space source or destination.
// - The move refuses a small set of special registers as destination.
// - Bank literal load copies the literal into the bank register in one cycle.
// - The upper four bits of the bank register always read zero.
module mcuid_core (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [15:0] instr_word,
  input  wire logic        neg_flag,
  input  wire logic        ext_set_en,
  input  wire logic [11:0] idx_base,
  input  wire logic [7:0]  mem_rdata,
  output var  logic [20:0] pc_ff,
  output var  logic [1:0]  phase_ff,
  output var  logic [11:0] mem_addr_ff,
  output var  logic        mem_rd_ff,
  output var  logic        mem_wr_ff,
  output var  logic [7:0]  mem_wdata_ff,
  output var  logic [7:0]  bank_select_ff,
  output var  logic        bad_word_ff
);
  mcuid_pkg::mcuid_state_e state_ff;
  mcuid_pkg::mcuid_state_e nxt_state;
  logic [15:0] ir_ff;
  logic [15:0] nxt_ir;
  logic [7:0]  rd_ff;
  logic [7:0]  nxt_rd;
  logic [20:0] nxt_pc;
  logic [11:0] nxt_mem_addr;
  logic        nxt_mem_rd;
  logic        nxt_mem_wr;
  logic [7:0]  nxt_mem_wdata;
  logic [7:0]  nxt_bank;
  logic        nxt_bad_word;
  logic [11:0] byte_addr;
  logic [20:0] br_ofs;
  logic [7:0]  clr_mask;
  logic        dec_clear;
  logic        dec_move;
  logic        ir_clear;
  logic        ir_branch;
  logic        ir_bank;
  logic        ir_move;
  logic        dst_blocked;

  // Phase sequencing shared by every instruction
  mcuid_phase_gen u_phase (
    .clk      (clk),
    .rstn     (rstn),
    .phase_ff (phase_ff)
  );

  // Operand address for byte and bit forms, from the word being decoded
  mcuid_addr_form u_addr (
    .file_addr  (instr_word[7:0]),
    .access_sel (instr_word[mcuid_pkg::ACCESS_POS]),
    .bank_sel   (bank_select_ff),
    .ext_set_en (ext_set_en),
    .idx_base   (idx_base),
    .data_addr  (byte_addr)
  );

  // Decode of the incoming word and of the latched word
  assign dec_clear = (instr_word[15:12] == mcuid_pkg::OPC_CLEAR_BIT);
  assign dec_move  = (instr_word[15:12] == mcuid_pkg::OPC_MOVE_SRC);
  assign ir_clear  = (ir_ff[15:12] == mcuid_pkg::OPC_CLEAR_BIT);
  assign ir_branch = (ir_ff[15:8] == mcuid_pkg::OPC_BRANCH_NEG);
  assign ir_bank   = (ir_ff[15:8] == mcuid_pkg::OPC_LOAD_BANK);
  assign ir_move   = (ir_ff[15:12] == mcuid_pkg::OPC_MOVE_SRC);

  assign br_ofs   = {{12{ir_ff[7]}}, ir_ff[7:0], 1'b0};
  // single-bit mask from the 3-bit index
  assign clr_mask = 8'h01 << ir_ff[mcuid_pkg::BIT_IDX_LSB +: 3];

  assign dst_blocked = (mem_addr_ff >= mcuid_pkg::NO_DEST_LO) &&
                       (mem_addr_ff <= mcuid_pkg::NO_DEST_HI);

  // Next-state of the sequencer, counter and memory port; flags are never driven
  always_comb
  begin
    nxt_state     = state_ff;
    nxt_ir        = ir_ff;
    nxt_rd        = rd_ff;
    nxt_pc        = pc_ff;
    nxt_mem_addr  = mem_addr_ff;
    nxt_mem_rd    = 1'b0;
    nxt_mem_wr    = 1'b0;
    nxt_mem_wdata = mem_wdata_ff;
    nxt_bank      = bank_select_ff;
    nxt_bad_word  = bad_word_ff;
    case (state_ff)
      mcuid_pkg::ST_EXEC:
      begin
        case (phase_ff)
          mcuid_pkg::PH_DECODE:
          begin
            nxt_ir = instr_word;
            // counter steps before any branch offset is added
            nxt_pc = pc_ff + mcuid_pkg::PC_STEP;
            // full 12-bit source, no bank involved
            if (dec_move)
              nxt_mem_addr = instr_word[11:0];
            // bank, indexed or access-bank source for the bit clear
            else
              nxt_mem_addr = byte_addr;
            nxt_mem_rd = dec_clear || dec_move;
          end
          mcuid_pkg::PH_READ:
          begin
            // source read lands here in cycle one
            nxt_rd = mem_rdata;
          end
          mcuid_pkg::PH_PROCESS:
          begin
            // only the selected bit is cleared
            if (ir_clear)
            begin
              nxt_mem_wdata = rd_ff & ~clr_mask;
              nxt_mem_wr    = 1'b1;
            end
          end
          default:
          begin
            // taken branch writes the counter in this final phase
            if (ir_branch && neg_flag)
            begin
              nxt_pc    = pc_ff + br_ofs;
              nxt_state = mcuid_pkg::ST_BR_NOP;
            end
            if (ir_bank)
              nxt_bank = {4'h0, ir_ff[3:0]};
            if (ir_move)
              nxt_state = mcuid_pkg::ST_MOVE2;
          end
        endcase
      end
      mcuid_pkg::ST_BR_NOP:
      begin
        // idle cycle, fetched word is discarded
        if (phase_ff == mcuid_pkg::PH_WRITE)
          nxt_state = mcuid_pkg::ST_EXEC;
      end
      default:
      begin
        case (phase_ff)
          mcuid_pkg::PH_DECODE:
          begin
            // second word carries prefix and destination
            nxt_ir       = instr_word;
            nxt_pc       = pc_ff + mcuid_pkg::PC_STEP;
            nxt_mem_addr = instr_word[11:0];
            nxt_bad_word = (instr_word[15:12] != mcuid_pkg::OPC_MOVE_DST);
          end
          mcuid_pkg::PH_PROCESS:
          begin
            // accumulator is just another location here
            nxt_mem_wdata = rd_ff;
            // blocked destination or a bad prefix suppresses the write
            nxt_mem_wr = !bad_word_ff && !dst_blocked;
          end
          mcuid_pkg::PH_WRITE:
            nxt_state = mcuid_pkg::ST_EXEC;
          default:
            nxt_mem_wr = 1'b0;
        endcase
      end
    endcase
  end

  // Registers of the sequencer group
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_ff       <= mcuid_pkg::ST_EXEC;
      ir_ff          <= mcuid_pkg::IR_RESET;
      rd_ff          <= 8'h00;
      pc_ff          <= mcuid_pkg::PC_RESET;
      mem_addr_ff    <= 12'h000;
      mem_rd_ff      <= 1'b0;
      mem_wr_ff      <= 1'b0;
      mem_wdata_ff   <= 8'h00;
      bank_select_ff <= mcuid_pkg::BANK_RESET;
      bad_word_ff    <= 1'b0;
    end
    else
    begin
      state_ff       <= nxt_state;
      ir_ff          <= nxt_ir;
      rd_ff          <= nxt_rd;
      pc_ff          <= nxt_pc;
      mem_addr_ff    <= nxt_mem_addr;
      mem_rd_ff      <= nxt_mem_rd;
      mem_wr_ff      <= nxt_mem_wr;
      mem_wdata_ff   <= nxt_mem_wdata;
      bank_select_ff <= nxt_bank;
      bad_word_ff    <= nxt_bad_word;
    end
  end

  // Checks on the sequencer, all in the single clock domain
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  phase_order_a: assert property (
    phase_ff == mcuid_pkg::PH_WRITE |=> phase_ff == mcuid_pkg::PH_DECODE)
    else $error("phase did not wrap to decode");

  strobe_phase_a: assert property (
    (mem_rd_ff |-> phase_ff == mcuid_pkg::PH_READ) and
    (mem_wr_ff |-> phase_ff == mcuid_pkg::PH_WRITE))
    else $error("memory strobe outside its phase");

  // bit clear writes back the read byte minus one bit
  clear_data_a: assert property (
    (mem_wr_ff && state_ff == mcuid_pkg::ST_EXEC && ir_clear) |->
      mem_wdata_ff == (rd_ff & ~clr_mask))
    else $error("bit clear wrote wrong data");

  // banked address uses the bank register
  bank_addr_a: assert property (
    (state_ff == mcuid_pkg::ST_EXEC && phase_ff == mcuid_pkg::PH_DECODE &&
     dec_clear && instr_word[mcuid_pkg::ACCESS_POS]) |=>
      mem_addr_ff == {$past(bank_select_ff[3:0]), $past(instr_word[7:0])})
    else $error("banked address wrong");

  index_addr_a: assert property (
    (state_ff == mcuid_pkg::ST_EXEC && phase_ff == mcuid_pkg::PH_DECODE &&
     dec_clear && !instr_word[mcuid_pkg::ACCESS_POS] && ext_set_en &&
     instr_word[7:0] <= mcuid_pkg::IDX_LIMIT) |=>
      mem_addr_ff == $past(idx_base) + {4'h0, $past(instr_word[7:0])})
    else $error("indexed address wrong");

  branch_target_a: assert property (
    (state_ff == mcuid_pkg::ST_EXEC && phase_ff == mcuid_pkg::PH_WRITE &&
     ir_branch && neg_flag) |=> pc_ff == $past(pc_ff) + $past(br_ofs))
    else $error("branch target wrong");

  // taken branch idles one whole cycle
  branch_idle_a: assert property (
    (state_ff == mcuid_pkg::ST_EXEC && phase_ff == mcuid_pkg::PH_WRITE &&
     ir_branch && neg_flag) |=>
      (state_ff == mcuid_pkg::ST_BR_NOP && !mem_rd_ff && !mem_wr_ff)[*4]
      ##1 state_ff == mcuid_pkg::ST_EXEC)
    else $error("taken branch idle cycle wrong");

  // move writes destination seven edges after decode of word one
  move_write_a: assert property (
    (state_ff == mcuid_pkg::ST_EXEC && phase_ff == mcuid_pkg::PH_DECODE &&
     dec_move) |=> mem_rd_ff ##6 (state_ff == mcuid_pkg::ST_MOVE2 &&
      phase_ff == mcuid_pkg::PH_WRITE))
    else $error("move sequence wrong");

  move_block_a: assert property (
    (state_ff == mcuid_pkg::ST_MOVE2 && mem_wr_ff) |->
      (!dst_blocked && mem_wdata_ff == rd_ff))
    else $error("move wrote a blocked destination");

  bank_upper_a: assert property (
    bank_select_ff[7:4] == 4'h0)
    else $error("bank upper nibble not zero");

  // bank literal lands in the write phase
  bank_load_a: assert property (
    (state_ff == mcuid_pkg::ST_EXEC && phase_ff == mcuid_pkg::PH_WRITE &&
     ir_bank) |=> bank_select_ff[3:0] == $past(ir_ff[3:0]))
    else $error("bank literal not loaded");

  // counter steps one word at every decode of the execute state
  pc_step_a: assert property (
    (state_ff == mcuid_pkg::ST_EXEC && phase_ff == mcuid_pkg::PH_DECODE) |=>
      pc_ff == $past(pc_ff) + mcuid_pkg::PC_STEP)
    else $error("counter did not step at decode");

  // a second word without its prefix never writes
  move_prefix_a: assert property (
    (state_ff == mcuid_pkg::ST_MOVE2 && bad_word_ff) |-> !mem_wr_ff)
    else $error("move wrote after a bad second word");

endmodule // mcuid_core
`default_nettype wire

/* File: bench/mcuid_mem_model.sv */
// Program and data memory model facing the instruction subset decoder
`timescale 1ns/1ps
`default_nettype none
module mcuid_mem_model (
  input  wire logic        clk,
  input  wire logic [20:0] pc_ff,
  input  wire logic [11:0] mem_addr_ff,
  input  wire logic        mem_rd_ff,
  input  wire logic        mem_wr_ff,
  input  wire logic [7:0]  mem_wdata_ff,
  output logic      [15:0] instr_word,
  output logic      [7:0]  mem_rdata
);
  logic [15:0] prog [64];
  logic [7:0]  dmem [4096];
  int          wr_count;
  // word pairing order
  // Byte counter steps by two per word; only 64 words, so high bits alias
  assign instr_word = prog[pc_ff[6:1]];
  // Unstrobed reads show inverted data so a stale capture cannot pass
  assign mem_rdata = mem_rd_ff ? dmem[mem_addr_ff] : ~dmem[mem_addr_ff];
  always @(posedge clk)
  begin
    if (mem_wr_ff === 1'b1)
    begin
      dmem[mem_addr_ff] <= mem_wdata_ff;
      wr_count <= wr_count + 1;
    end
  end
endmodule // mcuid_mem_model
`default_nettype wire

/* File: bench/test_mcu_instr_subset_decode.sv */
// Self-checking testbench of the instruction subset decoder
`timescale 1ns/1ps
`default_nettype none
module test_mcu_instr_subset_decode;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        neg_flag = 1'b0;
  logic        ext_set_en = 1'b0;
  logic [11:0] idx_base = 12'h100;
  logic [15:0] instr_word;
  logic [7:0]  mem_rdata;
  logic [20:0] pc_ff;
  logic [1:0]  phase_ff;
  logic [11:0] mem_addr_ff;
  logic        mem_rd_ff;
  logic        mem_wr_ff;
  logic [7:0]  mem_wdata_ff;
  logic [7:0]  bank_select_ff;
  logic        bad_word_ff;
  int          miscompares = 0;
  int          comparisons = 0;

  // 25 MHz clock
  always #20 clk = ~clk;

  mcuid_core dut_u (.clk(clk), .rstn(rstn), .instr_word(instr_word), .neg_flag(neg_flag),
    .ext_set_en(ext_set_en), .idx_base(idx_base), .mem_rdata(mem_rdata), .pc_ff(pc_ff),
    .phase_ff(phase_ff), .mem_addr_ff(mem_addr_ff), .mem_rd_ff(mem_rd_ff),
    .mem_wr_ff(mem_wr_ff), .mem_wdata_ff(mem_wdata_ff), .bank_select_ff(bank_select_ff),
    .bad_word_ff(bad_word_ff));

  mcuid_mem_model mem_u (.clk(clk), .pc_ff(pc_ff), .mem_addr_ff(mem_addr_ff),
    .mem_rd_ff(mem_rd_ff), .mem_wr_ff(mem_wr_ff), .mem_wdata_ff(mem_wdata_ff),
    .instr_word(instr_word), .mem_rdata(mem_rdata));

  // One comparison; four-state so an unknown never matches
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Reset and blank memories; unknown words 0000 run as no-ops
  task automatic hold();
    rstn = 1'b0;
    for (int i = 0; i < 64; i++) mem_u.prog[i] = 16'h0000;
    for (int i = 0; i < 4096; i++) mem_u.dmem[i] = 8'hff;
    mem_u.wr_count = 0;
    @(negedge clk);
  endtask

  // Release at a falling edge; the next rising edge decodes pc 0
  task automatic go(input logic neg, input logic ext);
    neg_flag = neg;
    ext_set_en = ext;
    @(negedge clk);
    rstn = 1'b1;
  endtask

  task automatic edges(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic t_reset();
    chk(pc_ff, 32'h0);
    chk(phase_ff, 32'h0);
    chk({mem_rd_ff, mem_wr_ff, bad_word_ff}, 32'h0);
    chk(bank_select_ff, 32'h0);
    $display("test reset done");
  endtask

  // Bank load, then bit clears through bank, indexed and access-bank paths
  task automatic t_bits();
    hold();
    mem_u.prog[0] = 16'h01a5;
    mem_u.prog[1] = 16'h9712;
    mem_u.prog[2] = 16'h9020;
    mem_u.prog[3] = 16'h9e60;
    go(1'b0, 1'b1);
    edges(4);
    chk(bank_select_ff, 32'h05);
    edges(1);
    chk({phase_ff, mem_rd_ff, mem_wr_ff}, 32'h6);
    edges(2);
    chk({phase_ff, mem_rd_ff, mem_wr_ff}, 32'hd);
    chk(mem_addr_ff, 32'h512);
    chk(mem_wdata_ff, 32'hf7);
    edges(9);
    chk(mem_u.dmem[12'h512], 32'hf7);
    chk(mem_u.dmem[12'h120], 32'hfe);
    chk(mem_u.dmem[12'hf60], 32'h7f);
    chk(mem_u.wr_count, 32'h3);
    chk(pc_ff, 32'h8);
    $display("test bit clear done");
  endtask

  // Taken branches at both offset bounds and at offset -2, then one not taken
  task automatic t_branch();
    logic [7:0]  offs [3];
    logic [20:0] tgt [3];
    offs = '{8'h7f, 8'h80, 8'hfe};
    tgt = '{21'h000100, 21'h1fff02, 21'h1ffffe};
    for (int i = 0; i < 3; i++)
    begin
      hold();
      mem_u.prog[0] = {8'he6, offs[i]};
      go(1'b1, 1'b0);
      edges(1);
      chk(pc_ff, 32'h2);
      edges(3);
      chk(pc_ff, {11'h0, tgt[i]});
      edges(4);
      chk({pc_ff, mem_rd_ff, mem_wr_ff}, {9'h0, tgt[i], 2'b00});
      edges(1);
      chk(pc_ff, {11'h0, tgt[i] + 21'h2});
    end
    hold();
    mem_u.prog[0] = 16'he67f;
    // Plain access-bank clear follows, extended set off
    mem_u.prog[1] = 16'h9020;
    go(1'b0, 1'b0);
    edges(4);
    chk(pc_ff, 32'h2);
    edges(1);
    chk(pc_ff, 32'h4);
    edges(3);
    chk(mem_u.dmem[12'h020], 32'hfe);
    $display("test branch done");
  endtask

  // Two-word moves: plain, full range, blocked target, bad prefix
  task automatic t_move();
    logic [15:0] w1 [4];
    logic [11:0] src [4];
    logic [11:0] dst [4];
    logic        ok [4];
    w1 = '{16'hf456, 16'hf000, 16'hfffe, 16'he456};
    src = '{12'h123, 12'hfff, 12'h123, 12'h123};
    dst = '{12'h456, 12'h000, 12'hffe, 12'h456};
    ok = '{1'b1, 1'b1, 1'b0, 1'b0};
    for (int i = 0; i < 4; i++)
    begin
      hold();
      mem_u.prog[0] = {4'hc, src[i]};
      mem_u.prog[1] = w1[i];
      mem_u.dmem[src[i]] = 8'h3c;
      go(1'b0, 1'b0);
      edges(1);
      chk({mem_rd_ff, mem_addr_ff}, {19'h0, 1'b1, src[i]});
      edges(6);
      chk(mem_wr_ff, ok[i]);
      edges(1);
      chk(mem_u.dmem[dst[i]], ok[i] ? 32'h3c : 32'hff);
      chk({mem_u.wr_count[3:0], bad_word_ff}, {27'h0, 3'h0, ok[i], i == 3});
      chk(pc_ff, 32'h4);
    end
    $display("test move done");
  endtask

  // Watchdog against a hang
  initial
  begin
    repeat (20000) @(posedge clk);
    miscompares++;
    conclude();
  end

  initial
  begin
    repeat (10) @(negedge clk);
    t_reset();
    t_bits();
    t_branch();
    t_move();
    conclude();
  end
endmodule // test_mcu_instr_subset_decode
`default_nettype wire
